// file: include/kbs_pkg.sv
// Constants, register map and state encoding for the kinetics burst sequencer.
// Assumes a single 40 MHz clock and a plain address/strobe register port.
//
// What this block does
// - Multiple-trigger mode: each sub-frame waits own trigger edge.
// - Clean only before first trigger, never later.
// - Cleaning shifts one row at a time.
// - Clean count zero disables pre-trigger cleaning.
// - Single-trigger mode: one trigger runs whole burst.
// - Modes: free-run, single-trigger, multiple-trigger.
// - Shift window-size rows per sub-frame.
// - Stop after frame, fresh start before next.
// - Report controller, camera, readout modes, default setpoint.
// - Flag temperature locked at commanded setpoint.
// - Rising edge default; invert input low selects falling.
// - After last cycle read out whole array.
package kbs_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int KBS_AW = 8;
    localparam int KBS_DW = 32;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] KBS_REG_CTRL = 8'h00;  // Mode, start, stop
    localparam logic [7:0] KBS_REG_WINDOW = 8'h04;  // Exposed rows per sub-frame
    localparam logic [7:0] KBS_REG_SUBS = 8'h08;  // Sub-frames per burst
    localparam logic [7:0] KBS_REG_EXPOSE = 8'h0C;  // Exposure in clock cycles
    localparam logic [7:0] KBS_REG_CLEANS = 8'h10;  // Pre-trigger row cleans
    localparam logic [7:0] KBS_REG_ARRAY = 8'h14;  // Rows read out at burst end
    localparam logic [7:0] KBS_REG_ROWTIME = 8'h18;  // Cycles per row shift
    localparam logic [7:0] KBS_REG_STATUS = 8'h1C;  // State and flags
    localparam logic [7:0] KBS_REG_IDENT = 8'h20;  // Controller, camera, modes
    localparam logic [7:0] KBS_REG_SETPOINT = 8'h24;  // Temperature setpoint
    localparam logic [7:0] KBS_REG_IRQ_STAT = 8'h28;  // Sticky events, read only
    localparam logic [7:0] KBS_REG_IRQ_CLR = 8'h2C;  // Write one to clear
    localparam logic [7:0] KBS_REG_IRQ_EN = 8'h30;  // Interrupt enable

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    localparam int KBS_CTRL_MODE_LO = 0;
    localparam int KBS_CTRL_START = 2;
    localparam int KBS_CTRL_STOP = 3;
    localparam logic [1:0] KBS_MODE_FREE = 2'h0;
    localparam logic [1:0] KBS_MODE_SINGLE = 2'h1;
    localparam logic [1:0] KBS_MODE_MULTI = 2'h2;

    // ----------------------------------------------------------------
    // Interrupt event bits
    // ----------------------------------------------------------------
    localparam int KBS_NEV = 4;
    localparam int KBS_EV_TRIG = 0;  // Trigger accepted
    localparam int KBS_EV_IGN = 1;  // Trigger ignored mid-cycle
    localparam int KBS_EV_DONE = 2;  // Frame read out
    localparam int KBS_EV_LOCK = 3;  // Temperature reached lock

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] KBS_RST_WINDOW = 16'h0001;
    localparam logic [15:0] KBS_RST_SUBS = 16'h0001;
    localparam logic [31:0] KBS_RST_EXPOSE = 32'h0000_0001;
    localparam logic [15:0] KBS_RST_CLEANS = 16'h0000;
    localparam logic [15:0] KBS_RST_ARRAY = 16'h0001;
    localparam logic [15:0] KBS_RST_ROWTIME = 16'h0001;
    localparam logic [3:0] KBS_READOUT_MODES = 4'h3;  // Full frame and kinetics

    // ----------------------------------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        KBS_IDLE = 7'h01,  // Waiting for a start command
        KBS_ARM = 7'h02,  // Cleaning and waiting for first trigger
        KBS_EXPOSE = 7'h04,  // Integrating the window
        KBS_SHIFT = 7'h08,  // Moving the window under the mask
        KBS_WAITT = 7'h10,  // Multiple trigger gap, no cleaning
        KBS_READ = 7'h20,  // Full array readout
        KBS_DONE = 7'h40  // Frame held until the host stops
    } kbs_state_e;

endpackage : kbs_pkg

// file: rtl/kbs_sequencer.sv
// Kinetics burst sequencer: trigger qualification, cleaning, exposure-shift
// cycles, final readout, start/stop handshake, temperature lock, interrupts.
// Assumes the trigger pins are asynchronous and temperature comes from
// a sampler running on clk_i.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module kbs_sequencer #(
    parameter logic [7:0] CTRL_TYPE = 8'h5A,  // Arbitrary value
    parameter logic [7:0] CAM_TYPE = 8'hA5,  // Arbitrary value
    parameter logic [15:0] DEF_SETPOINT = 16'h0000  // Plain default setpoint
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [kbs_pkg::KBS_AW-1:0] addr_i,
    input wire logic [kbs_pkg::KBS_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [kbs_pkg::KBS_DW-1:0] rdata_o,
    // Trigger pins
    input wire logic trig_i,
    input wire logic trig_inv_n_i,
    // Temperature sample, signed, same clock
    input wire logic [15:0] temp_i,
    // Sensor control outputs
    output logic expose_o,
    output logic vshift_o,
    output logic readout_o,
    output logic clean_o,
    output logic irq_o
);
    import kbs_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    kbs_state_e state;  // Current sequencer state
    kbs_state_e next_state;  // Next sequencer state
    logic [1:0] mode;  // Timing mode
    logic [15:0] win_rows;  // Window size in rows
    logic [15:0] subs_cfg;  // Sub-frames per burst
    logic [31:0] exp_cyc;  // Exposure cycles
    logic [15:0] clean_cfg;  // Row cleans before first trigger
    logic [15:0] array_rows;  // Rows in full readout
    logic [15:0] row_cyc;  // Cycles per row shift
    logic [15:0] setpoint;  // Commanded temperature
    logic [KBS_NEV-1:0] irq_stat;  // Sticky events
    logic [KBS_NEV-1:0] irq_en;  // Event enables
    logic [31:0] tmr;  // Down counter
    logic [31:0] next_tmr;
    logic [15:0] rows;  // Rows left in current group
    logic [15:0] next_rows;
    logic [15:0] subs;  // Sub-frames left
    logic [15:0] next_subs;
    logic pend;  // Trigger seen mid-row while cleaning
    logic next_pend;
    logic locked;  // Temperature lock flag
    logic shift_pulse;  // One row moved this cycle
    logic ev_trig;
    logic ev_ign;
    logic ev_done;

    // ----------------------------------------------------------------
    // Trigger synchronisers
    // ----------------------------------------------------------------
    // Two flops each; the second stage and the trigger's delayed copy feed logic
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;  // Delayed copy for edge detection
    logic inv_s1;
    logic inv_s2;

    // Synchroniser chain
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            inv_s1 <= 1'b1;
            inv_s2 <= 1'b1;
        end
        else
        begin
            trig_s1 <= trig_i;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            inv_s1 <= trig_inv_n_i;
            inv_s2 <= inv_s1;
        end
    end

    // Qualified edge: rising by default, falling when invert is pulled low
    wire trig_rise = trig_s2 & ~trig_s3;
    wire trig_fall = ~trig_s2 & trig_s3;
    wire trig_edge = inv_s2 ? trig_rise : trig_fall;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire wr_ctrl = wr_i && (addr_i == KBS_REG_CTRL);
    wire wr_window = wr_i && (addr_i == KBS_REG_WINDOW);
    wire wr_subs = wr_i && (addr_i == KBS_REG_SUBS);
    wire wr_expose = wr_i && (addr_i == KBS_REG_EXPOSE);
    wire wr_cleans = wr_i && (addr_i == KBS_REG_CLEANS);
    wire wr_array = wr_i && (addr_i == KBS_REG_ARRAY);
    wire wr_rowtime = wr_i && (addr_i == KBS_REG_ROWTIME);
    wire wr_setpoint = wr_i && (addr_i == KBS_REG_SETPOINT);
    wire wr_irq_clr = wr_i && (addr_i == KBS_REG_IRQ_CLR);
    wire wr_irq_en = wr_i && (addr_i == KBS_REG_IRQ_EN);
    wire start_cmd = wr_ctrl && wdata_i[KBS_CTRL_START];
    wire stop_cmd = wr_ctrl && wdata_i[KBS_CTRL_STOP];

    // Helper terms for the sequencer
    wire tmr_end = (tmr <= 32'h0000_0001);
    wire row_last = (rows <= 16'h0001);
    wire sub_last = (subs <= 16'h0001);
    wire [31:0] row_load = {16'h0000, row_cyc};
    wire is_busy = (state == KBS_EXPOSE) || (state == KBS_SHIFT);

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    // All counters advance here so the clocked block stays a plain copy
    always_comb
    begin
        next_state = state;
        next_tmr = (tmr == 32'h0000_0000) ? tmr : tmr - 32'h0000_0001;
        next_rows = rows;
        next_subs = subs;
        next_pend = pend;
        shift_pulse = 1'b0;
        ev_trig = 1'b0;
        ev_ign = 1'b0;
        ev_done = 1'b0;
        case (state)
            KBS_IDLE:
            begin
                // Nothing is acquired until the host starts a frame
                if (start_cmd)
                begin
                    next_subs = subs_cfg;
                    next_pend = 1'b0;
                    if (mode == KBS_MODE_FREE)
                    begin
                        next_state = KBS_EXPOSE;
                        next_tmr = exp_cyc;
                    end
                    else
                    begin
                        next_state = KBS_ARM;
                        next_rows = clean_cfg;
                        next_tmr = row_load;
                    end
                end
            end
            KBS_ARM:
            begin
                // Cleaning runs only in this state, before the first trigger
                if (rows == 16'h0000)
                begin
                    if (trig_edge)
                    begin
                        next_state = KBS_EXPOSE;
                        next_tmr = exp_cyc;
                        ev_trig = 1'b1;
                    end
                end
                else
                begin
                    // A trigger mid-row waits for the row to finish: jitter of one row
                    if (trig_edge)
                    begin
                        next_pend = 1'b1;
                    end
                    if (tmr_end)
                    begin
                        shift_pulse = 1'b1;
                        next_rows = rows - 16'h0001;
                        next_tmr = row_load;
                        if (pend || trig_edge)
                        begin
                            next_state = KBS_EXPOSE;
                            next_tmr = exp_cyc;
                            next_pend = 1'b0;
                            ev_trig = 1'b1;
                        end
                    end
                end
            end
            KBS_EXPOSE:
            begin
                // Triggers during a cycle are dropped, never queued
                ev_ign = trig_edge;
                if (tmr_end)
                begin
                    next_state = KBS_SHIFT;
                    next_rows = win_rows;
                    next_tmr = row_load;
                end
            end
            KBS_SHIFT:
            begin
                ev_ign = trig_edge;
                if (tmr_end)
                begin
                    shift_pulse = 1'b1;
                    next_tmr = row_load;
                    if (!row_last)
                    begin
                        next_rows = rows - 16'h0001;
                    end
                    else if (sub_last)
                    begin
                        // Burst complete: read out the whole array
                        next_state = KBS_READ;
                        next_rows = array_rows;
                    end
                    else if (mode == KBS_MODE_MULTI)
                    begin
                        next_subs = subs - 16'h0001;
                        next_state = KBS_WAITT;
                    end
                    else
                    begin
                        // Single trigger and free run continue unaided
                        next_subs = subs - 16'h0001;
                        next_state = KBS_EXPOSE;
                        next_tmr = exp_cyc;
                    end
                end
            end
            KBS_WAITT:
            begin
                // No cleaning in gaps between later triggers
                if (trig_edge)
                begin
                    next_state = KBS_EXPOSE;
                    next_tmr = exp_cyc;
                    ev_trig = 1'b1;
                end
            end
            KBS_READ:
            begin
                if (tmr_end)
                begin
                    shift_pulse = 1'b1;
                    next_tmr = row_load;
                    next_rows = rows - 16'h0001;
                    if (row_last)
                    begin
                        next_state = KBS_DONE;
                        ev_done = 1'b1;
                    end
                end
            end
            KBS_DONE:
            begin
                // Frame held; a start here is ignored until the host stops
                next_state = KBS_DONE;
            end
            default:
            begin
                next_state = KBS_IDLE;
            end
        endcase
        // Stop returns to idle from any active state
        if (stop_cmd && (state != KBS_IDLE))
        begin
            next_state = KBS_IDLE;
            next_pend = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer registers and pin outputs
    // ----------------------------------------------------------------
    // Outputs follow the next state and the shift pulse so each pin is a flop
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= KBS_IDLE;
            tmr <= 32'h0000_0000;
            rows <= 16'h0000;
            subs <= 16'h0000;
            pend <= 1'b0;
            expose_o <= 1'b0;
            vshift_o <= 1'b0;
            readout_o <= 1'b0;
            clean_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            tmr <= next_tmr;
            rows <= next_rows;
            subs <= next_subs;
            pend <= next_pend;
            expose_o <= (next_state == KBS_EXPOSE);
            vshift_o <= shift_pulse;
            readout_o <= (next_state == KBS_READ);
            clean_o <= (next_state == KBS_ARM) && (next_rows != 16'h0000);
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Changing settings other than mode mid-burst takes effect on the next load only; mode is read live at each sub-frame end
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mode <= KBS_MODE_FREE;
            win_rows <= KBS_RST_WINDOW;
            subs_cfg <= KBS_RST_SUBS;
            exp_cyc <= KBS_RST_EXPOSE;
            clean_cfg <= KBS_RST_CLEANS;
            array_rows <= KBS_RST_ARRAY;
            row_cyc <= KBS_RST_ROWTIME;
            setpoint <= DEF_SETPOINT;
            irq_en <= '0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                mode <= wdata_i[KBS_CTRL_MODE_LO +: 2];
            end
            if (wr_window)
            begin
                win_rows <= wdata_i[15:0];
            end
            if (wr_subs)
            begin
                subs_cfg <= wdata_i[15:0];
            end
            if (wr_expose)
            begin
                exp_cyc <= wdata_i;
            end
            if (wr_cleans)
            begin
                clean_cfg <= wdata_i[15:0];
            end
            if (wr_array)
            begin
                array_rows <= wdata_i[15:0];
            end
            if (wr_rowtime)
            begin
                row_cyc <= wdata_i[15:0];
            end
            if (wr_setpoint)
            begin
                setpoint <= wdata_i[15:0];
            end
            if (wr_irq_en)
            begin
                irq_en <= wdata_i[KBS_NEV-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Temperature lock and interrupts
    // ----------------------------------------------------------------
    // Cooling target: locked once the array is at or below the setpoint
    wire at_setpoint = $signed(temp_i) <= $signed(setpoint);
    wire [KBS_NEV-1:0] events = {at_setpoint & ~locked, ev_done, ev_ign, ev_trig};
    wire [KBS_NEV-1:0] clr_mask = wr_irq_clr ? wdata_i[KBS_NEV-1:0] : '0;
    // Set beats clear so an event in the clearing cycle survives
    wire [KBS_NEV-1:0] next_irq_stat = (irq_stat & ~clr_mask) | events;

    // Sticky status, lock flag and interrupt line
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            locked <= 1'b0;
            irq_stat <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            locked <= at_setpoint;
            irq_stat <= next_irq_stat;
            irq_o <= |(next_irq_stat & irq_en);
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    wire [31:0] status_word = {16'h0000, subs[7:0], locked, is_busy, state[5:0]};
    wire [31:0] ident_word = {12'h000, KBS_READOUT_MODES, CAM_TYPE, CTRL_TYPE};
    wire [31:0] rd_mux =
        (addr_i == KBS_REG_CTRL) ? {30'h0000_0000, mode} :
        (addr_i == KBS_REG_WINDOW) ? {16'h0000, win_rows} :
        (addr_i == KBS_REG_SUBS) ? {16'h0000, subs_cfg} :
        (addr_i == KBS_REG_EXPOSE) ? exp_cyc :
        (addr_i == KBS_REG_CLEANS) ? {16'h0000, clean_cfg} :
        (addr_i == KBS_REG_ARRAY) ? {16'h0000, array_rows} :
        (addr_i == KBS_REG_ROWTIME) ? {16'h0000, row_cyc} :
        (addr_i == KBS_REG_STATUS) ? status_word :
        (addr_i == KBS_REG_IDENT) ? ident_word :
        (addr_i == KBS_REG_SETPOINT) ? {16'h0000, setpoint} :
        (addr_i == KBS_REG_IRQ_STAT) ? {28'h000_0000, irq_stat} :
        (addr_i == KBS_REG_IRQ_EN) ? {28'h000_0000, irq_en} :
        32'h0000_0000;

    // Read data valid in the cycle after the strobe only
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_o <= 32'h0000_0000;
        end
        else
        begin
            rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
        end
    end

endmodule : kbs_sequencer

`default_nettype wire

// file: tb/kbs_sequencer_props.sv
// Checker: port-level properties of the sequencer.
// Assumes binding to every sequencer instance.
`timescale 1ns/100ps
`default_nettype none
module kbs_sequencer_props #(
    parameter logic [7:0] CTRL_TYPE = 8'h5A,
    parameter logic [7:0] CAM_TYPE = 8'hA5
) (
    // Watched ports
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [kbs_pkg::KBS_AW-1:0] addr_i,
    input wire logic [kbs_pkg::KBS_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [kbs_pkg::KBS_DW-1:0] rdata_o,
    input wire logic expose_o,
    input wire logic readout_o,
    input wire logic clean_o
);
    import kbs_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_clean_exp; clean_o |-> !expose_o; endproperty
    a_clean_exp: assert property (p_clean_exp) else $error("clean in exposure");
    property p_clean_rd; clean_o |-> !readout_o; endproperty
    a_clean_rd: assert property (p_clean_rd) else $error("clean in readout");
    property p_exp_rd; readout_o |-> !expose_o; endproperty
    a_exp_rd: assert property (p_exp_rd) else $error("exposure in readout");
    property p_idle; !$past(rd_i) |-> rdata_o == '0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_ident;
        rd_i && addr_i == KBS_REG_IDENT |=>
            rdata_o == {12'h000, KBS_READOUT_MODES, CAM_TYPE, CTRL_TYPE};
    endproperty
    a_ident: assert property (p_ident) else $error("ident word wrong");
    property p_unmap; rd_i && addr_i > KBS_REG_IRQ_EN |=> rdata_o == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_clr; rd_i && addr_i == KBS_REG_IRQ_CLR |=> rdata_o == '0; endproperty
    a_clr: assert property (p_clr) else $error("clear register readable");
    property p_win;
        wr_i && addr_i == KBS_REG_WINDOW ##1 rd_i && addr_i == KBS_REG_WINDOW
            |=> rdata_o == {16'h0000, $past(wdata_i[15:0], 2)};
    endproperty
    a_win: assert property (p_win) else $error("window readback wrong");
endmodule : kbs_sequencer_props
bind kbs_sequencer kbs_sequencer_props #(.CTRL_TYPE(CTRL_TYPE), .CAM_TYPE(CAM_TYPE)) u_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .expose_o(expose_o), .readout_o(readout_o),
    .clean_o(clean_o));
`default_nettype wire

// file: tb/kbs_trig_src.sv
// Trigger source model: one pulse per fire request.
// Assumes fire_i is a one-cycle request on clk_i.
`timescale 1ns/100ps
`default_nettype none
module kbs_trig_src (
    // Clock and request
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic rising_i,
    // Trigger pin
    output logic trig_o
);
    logic [2:0] left = 3'h0; // Pulse cycles left
    // One pulse per request, never repeats by itself
    always @(posedge clk_i)
        left <= fire_i ? 3'h4 : left - 3'(left != 3'h0);
    // Idle at the inactive level, so only the leading edge qualifies
    assign trig_o = (left != 3'h0) ^ !rising_i;
endmodule : kbs_trig_src
`default_nettype wire

// file: tb/tb_top.sv
// Testbench: host register traffic and trigger stimulus for the sequencer.
// Assumes the trigger source model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import kbs_pkg::*;
    logic clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, fire = 0, inv = 1;
    logic [7:0] addr_i = 0;
    logic [31:0] wdata_i = 0, rdata_o;
    logic [15:0] temp_i = 16'h0020;
    logic trig_i, expose_o, vshift_o, readout_o, clean_o, irq_o, exp_q = 0;
    int err_count = 0, total_checks = 0, n_vs = 0, n_exp = 0, n_ro = 0;
    kbs_sequencer #(.CTRL_TYPE(8'h3C), .CAM_TYPE(8'hC3), .DEF_SETPOINT(16'h0123)) u_kbs_sequencer (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i), .trig_inv_n_i(inv),
        .temp_i(temp_i), .expose_o(expose_o), .vshift_o(vshift_o),
        .readout_o(readout_o), .clean_o(clean_o), .irq_o(irq_o));
    kbs_trig_src u_kbs_trig_src (.clk_i(clk_i), .fire_i(fire), .rising_i(inv), .trig_o(trig_i));
    initial
        forever #12.5 clk_i = !clk_i;
    // Counts row shifts, exposure starts and readout cycles
    always @(posedge clk_i)
    begin
        exp_q <= expose_o;
        n_ro <= n_ro + int'(readout_o);
        n_vs <= n_vs + int'(vshift_o);
        n_exp <= n_exp + int'(expose_o && !exp_q);
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Gap cycle only when a write strobe is still up
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (wr_i)
            @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask : rd
    task automatic fire_once;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask : fire_once
    task automatic regs;
        logic [31:0] d;
        rd(KBS_REG_CLEANS, d);
        chk("cleans reset", 32'h0, d);
        rd(KBS_REG_IDENT, d);
        chk("ident", 32'h0003_C33C, d);
        rd(KBS_REG_SETPOINT, d);
        chk("setpoint", 32'h0123, d);
        rd(8'h40, d);
        chk("unmapped", 32'h0, d);
        rd(KBS_REG_IRQ_CLR, d);
        chk("clear reads zero", 32'h0, d);
        wr(KBS_REG_WINDOW, 32'h3);
        rd(KBS_REG_WINDOW, d);
        chk("window", 32'h3, d);
        wr(KBS_REG_SUBS, 32'h2);
        wr(KBS_REG_ARRAY, 32'h2);
        wr(KBS_REG_EXPOSE, 32'h14);
        wr(KBS_REG_IRQ_EN, 32'h4);
        wr(KBS_REG_SETPOINT, 32'h10);
        // Lock flag sees the new setpoint one cycle after the write
        @(posedge clk_i);
        rd(KBS_REG_STATUS, d);
        chk("unlocked", 32'h0, 32'(d[7]));
        temp_i <= 16'h0008;
        repeat (4) @(posedge clk_i);
        rd(KBS_REG_STATUS, d);
        chk("locked", 32'h1, 32'(d[7]));
    endtask : regs
    // One burst; in triggered modes a second trigger lands mid-exposure and must be dropped
    task automatic burst(input logic [1:0] m, input int cl, input logic pol);
        logic [31:0] d;
        int bv, be, br;
        inv <= pol;
        wr(KBS_REG_CLEANS, 32'(cl));
        wr(KBS_REG_CTRL, {30'h0, m});
        bv = n_vs;
        be = n_exp;
        br = n_ro;
        wr(KBS_REG_CTRL, {29'h0, 1'b1, m});
        repeat (30) @(posedge clk_i);
        if (m != KBS_MODE_FREE)
        begin
            chk("early exposures", 32'h0, 32'(n_exp - be));
            chk("clean rows", 32'(cl), 32'(n_vs - bv));
            chk("clean after series", 32'h0, 32'(clean_o));
            fire_once;
            repeat (12) @(posedge clk_i);
            fire_once;
            repeat (60) @(posedge clk_i);
        end
        if (m == KBS_MODE_MULTI)
        begin
            chk("multi gap", 32'h1, 32'(n_exp - be));
            chk("gap clean", 32'h0, 32'(clean_o));
            fire_once;
        end
        for (int n = 0; n < 400 && irq_o !== 1'b1; n++)
            @(posedge clk_i);
        chk("done irq", 32'h1, 32'(irq_o));
        wr(KBS_REG_CTRL, {29'h0, 1'b1, m});
        repeat (10) @(posedge clk_i);
        chk("exposures", 32'h2, 32'(n_exp - be));
        chk("row shifts", 32'(cl * int'(m != 0) + 8), 32'(n_vs - bv));
        chk("readout cycles", 32'h2, 32'(n_ro - br));
        rd(KBS_REG_IRQ_STAT, d);
        chk("events", (m == KBS_MODE_FREE) ? 32'h4 : 32'h7, d & 32'h7);
        wr(KBS_REG_IRQ_CLR, 32'hF);
        @(posedge clk_i);
        chk("irq cleared", 32'h0, 32'(irq_o));
        wr(KBS_REG_CTRL, 32'h8);
        rd(KBS_REG_STATUS, d);
        chk("idle after stop", 32'h1, d & 32'h3F);
    endtask : burst
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial
    begin
        #125000;
        err_count++;
        end_of_test;
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        regs;
        burst(KBS_MODE_FREE, 2, 1'b1);
        burst(KBS_MODE_SINGLE, 0, 1'b1);
        burst(KBS_MODE_SINGLE, 3, 1'b0);
        burst(KBS_MODE_MULTI, 2, 1'b1);
        end_of_test;
    end
endmodule : tb_top
`default_nettype wire
